// ==== sbl_stage_block_latch_output_matrix.sv ====
// Stage blocking, trip latching and output routing matrix with APB registers
// Summary of operation
// - All blocking bits clear blocks nothing
// - Bits 1-4 let control input block stages
// - Bank bit clear: input ignores setting bank
// - Bank bit set: input selects second bank
// - Overcurrent trip follows measurement when unlatched
// - Overcurrent trip held until reset when latched
// - Earth-fault trip latched likewise by bit 7
// - Both buttons clear latches and starts
// - Control input resets latch if bit 8
// - Blocking register resets to zero
// - Program button alone clears latch only
// - First routing feeds start and main trip
// - Second routing feeds second, third outputs
// - Third routing feeds auxiliary trip output
// - First routing odd starts, even trips
// - Second routing odd second, even third
// - Third routing odd starts, even trips
`timescale 1ns/100ps
`include "sbl_regs.svh"
module sbl_stage_block_latch_output_matrix (
	input  wire logic              sys_clk,
	input  wire logic              arst_n,
	input  wire sbl_pkg::sbl_apb_req_t apbReq,
	output sbl_pkg::sbl_apb_rsp_t  apbRsp,
	input  wire sbl_pkg::sbl_stage_t stageIn,
	input  wire logic              cbFailIn,
	input  wire logic              extControlIn,
	input  wire logic              resetButton,
	input  wire logic              programButton,
	input  wire logic              serialBankSel,
	output sbl_pkg::sbl_out_t      relayOut,
	output logic                   secondBankActive,
	output logic                   startIndicationClear
);
	import sbl_pkg::*;

	logic        rstMeta_r;
	logic        rstSync_n;
	logic        ctrlSync;
	logic        rstBtnSync;
	logic        progBtnSync;
	logic [7:0]  blockSw_r;
	logic [7:0]  blockSw_nxt;
	logic [7:0]  route1_r;
	logic [7:0]  route1_nxt;
	logic [7:0]  route2_r;
	logic [7:0]  route2_nxt;
	logic [7:0]  route3_r;
	logic [7:0]  route3_nxt;
	logic [7:0]  funcSw_r;
	logic [7:0]  funcSw_nxt;
	logic [1:0]  swReset;
	sbl_apb_st_t apbSt_r;
	sbl_apb_st_t apbSt_nxt;
	sbl_apb_rsp_t apbRsp_r;
	sbl_apb_rsp_t apbRsp_nxt;
	logic        ocLatch_r;
	logic        ocLatch_nxt;
	logic        efLatch_r;
	logic        efLatch_nxt;
	logic        ctrlPrev_r;
	logic        ctrlPrev_nxt;
	sbl_out_t    out_r;
	sbl_out_t    out_nxt;
	logic        bank_r;
	logic        bank_nxt;
	logic        clrStart_r;
	logic        clrStart_nxt;
	logic [3:0]  stageBlocked;
	logic [3:0]  startEff;
	logic [3:0]  tripEff;
	logic [3:0]  firstHit;
	logic [3:0]  mainHit;
	logic [3:0]  secondHit;
	logic [3:0]  thirdHit;
	logic [3:0]  auxHit;
	logic        remoteRst;
	logic        fullReset;
	logic        latchReset;
	logic        ocTripLive;
	logic        efTripLive;
	logic        sel;
	logic        wr;

	// Reset release through two flops
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rstMeta_r <= 1'b0;
			rstSync_n <= 1'b0;
		end else begin
			rstMeta_r <= 1'b1;
			rstSync_n <= rstMeta_r;
		end
	end

	// Pins come from switchgear wiring and front panel
	sbl_sync uCtrl (
		.sys_clk   (sys_clk),
		.rstSync_n (rstSync_n),
		.asyncIn   (extControlIn),
		.syncOut   (ctrlSync)
	);
	sbl_sync uRstBtn (
		.sys_clk   (sys_clk),
		.rstSync_n (rstSync_n),
		.asyncIn   (resetButton),
		.syncOut   (rstBtnSync)
	);
	sbl_sync uProgBtn (
		.sys_clk   (sys_clk),
		.rstSync_n (rstSync_n),
		.asyncIn   (programButton),
		.syncOut   (progBtnSync)
	);

	// APB slave, one wait-free access phase
	assign sel = apbReq.psel & apbReq.penable & (apbSt_r == SBL_ACCESS);
	assign wr  = sel & apbReq.pwrite;

	always_comb begin
		apbSt_nxt   = apbSt_r;
		apbRsp_nxt  = '0;
		blockSw_nxt = blockSw_r;
		route1_nxt  = route1_r;
		route2_nxt  = route2_r;
		route3_nxt  = route3_r;
		funcSw_nxt  = funcSw_r;
		swReset     = 2'b00;
		case (apbSt_r)
			SBL_IDLE: begin
				if (apbReq.psel && !apbReq.penable) begin
					apbSt_nxt = SBL_ACCESS;
				end
			end
			SBL_ACCESS: begin
				// A setup that follows at once re-arms the access phase
				apbSt_nxt = SBL_IDLE;
				if (apbReq.psel && !apbReq.penable) begin
					apbSt_nxt = SBL_ACCESS;
				end
			end
			default: begin
				apbSt_nxt = SBL_IDLE;
			end
		endcase
		// Read word captured in the setup cycle so prdata leaves a flop
		if (apbReq.psel) begin
			case (apbReq.paddr)
				`SBL_OFF_BLOCK: begin
					apbRsp_nxt.prdata = {24'h000000, blockSw_r};
					if (wr) begin
						blockSw_nxt = apbReq.pwdata[7:0];
					end
				end
				`SBL_OFF_ROUTE1: begin
					apbRsp_nxt.prdata = {24'h000000, route1_r};
					if (wr) begin
						route1_nxt = apbReq.pwdata[7:0];
					end
				end
				`SBL_OFF_ROUTE2: begin
					apbRsp_nxt.prdata = {24'h000000, route2_r};
					if (wr) begin
						route2_nxt = apbReq.pwdata[7:0];
					end
				end
				`SBL_OFF_ROUTE3: begin
					apbRsp_nxt.prdata = {24'h000000, route3_r};
					if (wr) begin
						route3_nxt = apbReq.pwdata[7:0];
					end
				end
				`SBL_OFF_FUNC: begin
					apbRsp_nxt.prdata = {24'h000000, funcSw_r};
					if (wr) begin
						funcSw_nxt = apbReq.pwdata[7:0];
					end
				end
				`SBL_OFF_STATUS: begin
					apbRsp_nxt.prdata = {22'h0, efLatch_r, ocLatch_r, bank_r, ctrlSync, 1'b0,
						out_r};
				end
				`SBL_OFF_CMD: begin
					if (wr) begin
						swReset = apbReq.pwdata[1:0];
					end
				end
				default: begin
					apbRsp_nxt.pslverr = 1'b1;
				end
			endcase
		end
	end

	// Ready is combinational so the access phase is always one cycle
	always_comb begin
		apbRsp         = apbRsp_r;
		apbRsp.pready  = 1'b1;
		apbRsp.pslverr = sel & apbRsp_r.pslverr;
		apbRsp.prdata  = sel ? apbRsp_r.prdata : 32'h00000000;
	end

	// Blocking, per stage
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : gStage
			assign stageBlocked[g] = blockSw_r[g] & ctrlSync;
			assign startEff[g]     = stageIn.start[g] & ~stageBlocked[g];
			assign tripEff[g]      = stageIn.trip[g] & ~stageBlocked[g];
			// Even bits of routes 1 and 3 route starts, odd bits trips; route 2 routes trips on both
			assign firstHit[g]     = startEff[g] & route1_r[2*g];
			assign mainHit[g]      = tripEff[g] & route1_r[2*g+1];
			assign secondHit[g]    = tripEff[g] & route2_r[2*g];
			assign thirdHit[g]     = tripEff[g] & route2_r[2*g+1];
			assign auxHit[g]       = (startEff[g] & route3_r[2*g])
				| (tripEff[g] & route3_r[2*g+1]);
		end
	endgenerate

	assign fullReset  = (rstBtnSync & progBtnSync) | swReset[`SBL_BIT_CMD_FULLRST];
	// Program alone clears latch only; status kept
	// Edge only, so a held contact cannot keep wiping new latches
	assign remoteRst  = blockSw_r[`SBL_BIT_REMRST] & ctrlSync & ~ctrlPrev_r
		& (blockSw_r[`SBL_BIT_OCLATCH] | blockSw_r[`SBL_BIT_EFLATCH]);
	assign latchReset = fullReset | (progBtnSync & ~rstBtnSync)
		| swReset[`SBL_BIT_CMD_PROGRST] | remoteRst;

	assign ocTripLive = |mainHit[1:0];
	assign efTripLive = |mainHit[3:2];

	always_comb begin
		ctrlPrev_nxt = ctrlSync;
		// Live trip wins over reset so a standing fault is never dropped
		ocLatch_nxt  = ocTripLive & blockSw_r[`SBL_BIT_OCLATCH];
		efLatch_nxt  = efTripLive & blockSw_r[`SBL_BIT_EFLATCH];
		// Clearing a latch bit drops a held trip at once
		if (!latchReset) begin
			ocLatch_nxt = ocLatch_nxt | (ocLatch_r & blockSw_r[`SBL_BIT_OCLATCH]);
			efLatch_nxt = efLatch_nxt | (efLatch_r & blockSw_r[`SBL_BIT_EFLATCH]);
		end
		// Bank follows input only when enabled, else serial link
		bank_nxt = blockSw_r[`SBL_BIT_BANKSEL] ? ctrlSync : serialBankSel;
		clrStart_nxt = fullReset;
		out_nxt.firstStart   = |firstHit;
		out_nxt.mainTrip     = ocTripLive | efTripLive | ocLatch_r | efLatch_r;
		out_nxt.secondSignal = |secondHit;
		out_nxt.thirdSignal  = |thirdHit;
		out_nxt.auxTrip      = (|auxHit)
			| (cbFailIn & funcSw_r[`SBL_BIT_CBFP]);
	end

	// Bus side: state, read word and switch registers
	always_ff @(posedge sys_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			apbSt_r    <= SBL_IDLE;
			apbRsp_r   <= '0;
			blockSw_r  <= `SBL_RST_BLOCK;
			route1_r   <= `SBL_RST_ROUTE1;
			route2_r   <= `SBL_RST_ROUTE2;
			route3_r   <= `SBL_RST_ROUTE3;
			funcSw_r   <= `SBL_RST_FUNC;
		end else begin
			apbSt_r    <= apbSt_nxt;
			apbRsp_r   <= apbRsp_nxt;
			blockSw_r  <= blockSw_nxt;
			route1_r   <= route1_nxt;
			route2_r   <= route2_nxt;
			route3_r   <= route3_nxt;
			funcSw_r   <= funcSw_nxt;
		end
	end

	// Protection side: latches, edge memory and outputs
	always_ff @(posedge sys_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			ocLatch_r  <= 1'b0;
			efLatch_r  <= 1'b0;
			ctrlPrev_r <= 1'b0;
			out_r      <= '0;
			bank_r     <= 1'b0;
			clrStart_r <= 1'b0;
		end else begin
			ocLatch_r  <= ocLatch_nxt;
			efLatch_r  <= efLatch_nxt;
			ctrlPrev_r <= ctrlPrev_nxt;
			out_r      <= out_nxt;
			bank_r     <= bank_nxt;
			clrStart_r <= clrStart_nxt;
		end
	end

	assign relayOut             = out_r;
	assign secondBankActive     = bank_r;
	assign startIndicationClear = clrStart_r;
endmodule

// ==== sbl_regs.svh ====
// Register offsets, field positions and reset values
`ifndef SBL_REGS_SVH
`define SBL_REGS_SVH

`define SBL_OFF_BLOCK      12'h000
`define SBL_OFF_ROUTE1     12'h004
`define SBL_OFF_ROUTE2     12'h008
`define SBL_OFF_ROUTE3     12'h00C
`define SBL_OFF_FUNC       12'h010
`define SBL_OFF_STATUS     12'h014
`define SBL_OFF_CMD        12'h018

`define SBL_RST_BLOCK      8'h00
`define SBL_RST_ROUTE1     8'hAB
`define SBL_RST_ROUTE2     8'hA5
`define SBL_RST_ROUTE3     8'h00
`define SBL_RST_FUNC       8'h00

`define SBL_BIT_BANKSEL    4
`define SBL_BIT_OCLATCH    5
`define SBL_BIT_EFLATCH    6
`define SBL_BIT_REMRST     7
`define SBL_BIT_CBFP       3

`define SBL_BIT_CMD_FULLRST 0
`define SBL_BIT_CMD_PROGRST 1

`endif

// ==== sbl_pkg.sv ====
// Types shared by the stage block and latch logic
package sbl_pkg;
	typedef struct packed {
		logic [3:0] start;
		logic [3:0] trip;
	} sbl_stage_t;

	typedef struct packed {
		logic auxTrip;
		logic mainTrip;
		logic firstStart;
		logic secondSignal;
		logic thirdSignal;
	} sbl_out_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} sbl_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} sbl_apb_rsp_t;

	typedef enum logic [1:0] {
		SBL_IDLE   = 2'b01,
		SBL_ACCESS = 2'b10
	} sbl_apb_st_t;
endpackage

// ==== sbl_sync.sv ====
// Two-flop synchroniser for a level input
`timescale 1ns/100ps
module sbl_sync (
	input  wire logic sys_clk,
	input  wire logic rstSync_n,
	input  wire logic asyncIn,
	output logic      syncOut
);
	logic meta_r;
	logic meta_nxt;
	logic sync_r;
	logic sync_nxt;

	always_comb begin
		meta_nxt = asyncIn;
		sync_nxt = meta_r;
	end

	always_ff @(posedge sys_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
		end else begin
			meta_r <= meta_nxt;
			sync_r <= sync_nxt;
		end
	end

	assign syncOut = sync_r;
endmodule

// ==== sbl_stage_block_monitor.sv ====
// Port-level assertions for the stage block matrix
`timescale 1ns/100ps
module sbl_stage_block_monitor (
	input wire logic                  sys_clk,
	input wire logic                  arst_n,
	input wire sbl_pkg::sbl_apb_req_t apbReq,
	input wire sbl_pkg::sbl_apb_rsp_t apbRsp,
	input wire sbl_pkg::sbl_stage_t   stageIn,
	input wire logic                  cbFailIn,
	input wire logic                  extControlIn,
	input wire logic                  resetButton,
	input wire logic                  programButton,
	input wire logic                  serialBankSel,
	input wire sbl_pkg::sbl_out_t     relayOut,
	input wire logic                  secondBankActive,
	input wire logic                  startIndicationClear
);
	import sbl_pkg::*;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	wire acc = apbReq.psel && apbReq.penable;
	apb_ready_a: assert property (acc |-> apbRsp.pready)
		else $error("pready low in access");
	idle_quiet_a: assert property (!acc |-> apbRsp.prdata == 32'h0 && !apbRsp.pslverr)
		else $error("bus answer outside access");
	unmapped_err_a: assert property (acc && apbReq.paddr > 12'h018 |-> apbRsp.pslverr)
		else $error("unmapped access not refused");
	mapped_ok_a: assert property (acc && apbReq.paddr <= 12'h018 && apbReq.paddr[1:0] == 2'h0
		|-> !apbRsp.pslverr) else $error("mapped access refused");
	start_quiet_a: assert property (stageIn.start == 4'h0 |=> !relayOut.firstStart)
		else $error("start output without start");
	signal_quiet_a: assert property (stageIn.trip == 4'h0 |=>
		!relayOut.secondSignal && !relayOut.thirdSignal) else $error("signal without trip");
	aux_quiet_a: assert property (stageIn == 8'h00 && !cbFailIn |=> !relayOut.auxTrip)
		else $error("aux trip without cause");
	prog_clear_a: assert property ((programButton && stageIn.trip == 4'h0)[*6]
		|-> !relayOut.mainTrip) else $error("latch survives program button");
	both_clear_a: assert property ((resetButton && programButton)[*8]
		|-> startIndicationClear) else $error("start clear missing");
	bank_idle_a: assert property ((!serialBankSel && !extControlIn)[*5]
		|-> !secondBankActive) else $error("second bank without request");
endmodule

// ==== sbl_field_model.sv ====
// Field wiring model: stage signals, control contact and buttons
`timescale 1ns/100ps
module sbl_field_model (
	input  wire logic         sys_clk,
	input  wire logic [11:0]  fieldCmd,
	output sbl_pkg::sbl_stage_t stageIn,
	output logic              cbFailIn,
	output logic              extControlIn,
	output logic              resetButton,
	output logic              programButton
);
	import sbl_pkg::*;
	initial {stageIn, cbFailIn, extControlIn, resetButton, programButton} = 12'h000;
	// Contacts close on an edge; both buttons may close together
	always @(posedge sys_clk) begin
		{stageIn, cbFailIn, extControlIn, resetButton, programButton} <= fieldCmd;
	end
endmodule

// ==== tb_sbl_stage_block_latch_output_matrix.sv ====
// Self-checking bench for the stage block matrix
`timescale 1ns/100ps
module tb_sbl_stage_block_latch_output_matrix;
	import sbl_pkg::*;
	localparam logic [7:0] R1 = 8'hAB;
	localparam logic [7:0] R2 = 8'hA5;
	logic         sys_clk = 1'b0;
	logic         arst_n = 1'b0;
	logic         serialBankSel = 1'b0;
	logic [11:0]  fc = 12'h000;
	sbl_apb_req_t apbReq = '0;
	sbl_apb_rsp_t apbRsp;
	sbl_stage_t   stageIn;
	sbl_out_t     relayOut;
	logic         cbFailIn, extControlIn, resetButton, programButton;
	logic         secondBankActive, startIndicationClear, er;
	logic [31:0]  rd;
	int           error_cnt = 0;
	int           checked = 0;
	sbl_stage_block_latch_output_matrix sbl_stage_block_latch_output_matrix_i (.sys_clk,
		.arst_n, .apbReq, .apbRsp, .stageIn, .cbFailIn, .extControlIn, .resetButton,
		.programButton, .serialBankSel, .relayOut, .secondBankActive, .startIndicationClear);
	sbl_field_model sbl_field_model_i (.sys_clk, .fieldCmd(fc), .stageIn, .cbFailIn,
		.extControlIn, .resetButton, .programButton);
	always #25 sys_clk = ~sys_clk;
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		checked++;
		if (got !== ex) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		apbReq <= '{1'b1, 1'b0, w, a, d};
		@(posedge sys_clk);
		apbReq.penable <= 1'b1;
		do begin
			@(posedge sys_clk);
		end while (apbRsp.pready !== 1'b1);
		rd = apbRsp.prdata;
		er = apbRsp.pslverr;
		apbReq.psel <= 1'b0;
		apbReq.penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] ex);
		apb(1'b0, a, 32'h0);
		chk(nm, ex, rd);
	endtask
	// Field change, then long enough for sync flops and output register
	task automatic fld(input logic [11:0] v, input logic s = 1'b0);
		@(posedge sys_clk);
		fc <= v;
		serialBankSel <= s;
		repeat (6) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask
	task automatic ro(input logic [4:0] ex);
		chk("relayOut", {27'h0, ex}, {27'h0, relayOut});
	endtask
	task automatic close_out;
		$display("Checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge sys_clk);
		arst_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		rc("block", 12'h000, 32'h00);
		rc("route1", 12'h004, 32'hAB);
		rc("route2", 12'h008, 32'hA5);
		rc("route3", 12'h00C, 32'h00);
		apb(1'b0, 12'h01C, 32'h0);
		chk("pslverr", 32'h1, {31'h0, er});
		wr(12'h008, 32'h5A);
		rc("route2wr", 12'h008, 32'h5A);
		wr(12'h008, {24'h0, R2});
		$display("test registers done");
		for (int i = 0; i < 4; i++) begin
			wr(12'h00C, 32'h2 << (2 * i));
			fld(12'h004 | (12'h110 << i));
			ro({1'b1, R1[2*i+1], R1[2*i], R2[2*i], R2[2*i+1]});
			wr(12'h000, 32'h1 << i);
			fld(12'h004 | (12'h110 << i));
			ro(5'h00);
			wr(12'h000, 32'h0);
			fld(12'h000);
			ro(5'h00);
		end
		wr(12'h00C, 32'h01);
		fld(12'h100);
		ro(5'h14);
		$display("test routing done");
		fld(12'h000, 1'b1);
		chk("bank", 32'h1, {31'h0, secondBankActive});
		fld(12'h004);
		chk("bank", 32'h0, {31'h0, secondBankActive});
		wr(12'h000, 32'h10);
		fld(12'h004);
		chk("bank", 32'h1, {31'h0, secondBankActive});
		fld(12'h000);
		chk("bank", 32'h0, {31'h0, secondBankActive});
		$display("test bank done");
		wr(12'h000, 32'h20);
		fld(12'h010);
		fld(12'h000);
		ro(5'h08);
		rc("status", 12'h014, 32'h108);
		fld(12'h001);
		ro(5'h00);
		fld(12'h010);
		fld(12'h003);
		ro(5'h00);
		chk("startClear", 32'h1, {31'h0, startIndicationClear});
		wr(12'h000, 32'hC0);
		fld(12'h040);
		fld(12'h000);
		ro(5'h08);
		chk("startClear", 32'h0, {31'h0, startIndicationClear});
		wr(12'h018, 32'h2);
		fld(12'h000);
		ro(5'h00);
		fld(12'h040);
		fld(12'h000);
		fld(12'h004);
		ro(5'h00);
		$display("test latch done");
		wr(12'h000, 32'h0);
		wr(12'h010, 32'h08);
		fld(12'h008);
		ro(5'h10);
		fld(12'h000);
		$display("test breaker done");
		close_out;
	end
	initial begin
		repeat (5000) @(posedge sys_clk);
		error_cnt++;
		close_out;
	end
endmodule
bind sbl_stage_block_latch_output_matrix sbl_stage_block_monitor sbl_stage_block_monitor_i (
	.sys_clk, .arst_n, .apbReq, .apbRsp, .stageIn, .cbFailIn, .extControlIn, .resetButton,
	.programButton, .serialBankSel, .relayOut, .secondBankActive, .startIndicationClear);
